// ---- rtl/sw_i2c_device.sv ----
`timescale 1ns/100ps
`include "sw_i2c_cfg.svh"
module sw_i2c_device
	import sw_i2c_pkg::*;
(
	// Clock and reset.
	input  wire logic       core_clk_in,
	input  wire logic       reset_n_in,
	// Strap and mode pins.
	input  wire logic [2:0] addr_sel_in,
	input  wire logic       mode_serial_in,
	// Two-wire link.
	sw_i2c_if.device        link,
	// Register bank view.
	output logic [7:0]      reg_ptr_out,
	output logic [7:0]      reg_bank_out [`REG_COUNT],
	output logic            wr_pulse_out
);
	dev_state_t state;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;
	logic [7:0] shift;
	logic [3:0] bit_cnt;
	logic       is_read;
	logic       got_ptr;
	logic       drive_low;
	logic [1:0] mode_meta;
	logic [2:0] sel_meta0;
	logic [2:0] sel_meta1;
	logic       mode_s;
	logic [7:0] reg_bank [`REG_COUNT];
	logic [7:0] rd_byte;

	// Line sampling and condition detection.
	sw_i2c_sync u_sync (
		.core_clk_in  (core_clk_in),
		.reset_n_in   (reset_n_in),
		.scl_in       (link.scl),
		.sda_in       (link.sda),
		.scl_out      (scl_s),
		.sda_out      (sda_s),
		.scl_rise_out (scl_rise),
		.scl_fall_out (scl_fall),
		.start_out    (start_c),
		.stop_out     (stop_c)
	);

	// Mode and strap pins come from outside; two flip-flops each.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in)
		begin
			mode_meta <= 2'h0;
			sel_meta0 <= 3'h0;
			sel_meta1 <= 3'h0;
		end
		else
		begin
			mode_meta <= {mode_meta[0], mode_serial_in};
			sel_meta0 <= addr_sel_in;
			sel_meta1 <= sel_meta0;
		end
	end
	assign mode_s = mode_meta[1];

	assign rd_byte = (reg_ptr_out < 8'(`REG_COUNT)) ? reg_bank[reg_ptr_out[2:0]] : 8'h00;

	// Protocol sequencer: bits are taken on rising clock, moves on falling, save DEV_TACK which leaves on rising.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in)
		begin
			state   <= DEV_IDLE;
			shift   <= 8'h00;
			bit_cnt <= 4'h0;
			is_read <= 1'b0;
			got_ptr <= 1'b0;
		end
		else if (!mode_s || stop_c)
		begin
			state <= DEV_IDLE;
		end
		else if (start_c)
		begin
			state   <= DEV_ADDR;
			bit_cnt <= 4'h0;
			got_ptr <= 1'b0;
		end
		else
		begin
			case (state)
				DEV_ADDR, DEV_RXB:
				begin
					if (scl_rise)
					begin
						shift   <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end
					else if (scl_fall && bit_cnt == 4'h8)
					begin
						bit_cnt <= 4'h0;
						if (state == DEV_RXB)
						begin
							state <= DEV_RACK;
						end
						else if (shift[7:1] == {`DEV_ADDR_PREFIX, sel_meta1})
						begin
							is_read <= shift[0];
							state   <= DEV_AACK;
						end
						else
						begin
							state <= DEV_SKIP;
						end
					end
				end
				DEV_AACK, DEV_RACK:
				begin
					if (scl_fall)
					begin
						if (state == DEV_RACK)
						begin
							got_ptr <= 1'b1;
						end
						if (state == DEV_AACK && is_read)
						begin
							shift <= rd_byte;
							state <= DEV_TXB;
						end
						else
						begin
							state <= DEV_RXB;
						end
					end
				end
				DEV_TXB:
				begin
					if (scl_fall)
					begin
						if (bit_cnt == 4'h7)
						begin
							bit_cnt <= 4'h0;
							state   <= DEV_TACK;
						end
						else
						begin
							bit_cnt <= bit_cnt + 4'h1;
							shift   <= {shift[6:0], 1'b0};
						end
					end
				end
				DEV_TACK:
				begin
					if (scl_rise)
					begin
						state <= DEV_SKIP;
					end
				end
				DEV_SKIP:
				begin
					state <= DEV_SKIP;
				end
				default:
				begin
					state <= DEV_IDLE;
				end
			endcase
		end
	end

	// Pointer and register stores, made as the acknowledge slot ends.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in)
		begin
			reg_ptr_out  <= `PTR_RESET;
			wr_pulse_out <= 1'b0;
			for (int i = 0; i < `REG_COUNT; i++)
			begin
				reg_bank[i] <= `REG_RESET;
			end
		end
		else
		begin
			wr_pulse_out <= 1'b0;
			if (mode_s && !start_c && !stop_c && state == DEV_RACK && scl_fall)
			begin
				if (!got_ptr)
				begin
					reg_ptr_out <= shift;
				end
				else
				begin
					wr_pulse_out <= 1'b1;
					if (reg_ptr_out < 8'(`REG_COUNT))
					begin
						reg_bank[reg_ptr_out[2:0]] <= shift;
					end
				end
			end
		end
	end

	// Data line drive, held between falling clock edges only.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in)
		begin
			drive_low <= 1'b0;
		end
		else
		begin
			drive_low <= (state == DEV_AACK || state == DEV_RACK) ||
				(state == DEV_TXB && !shift[7]);
		end
	end

	// Register bank view for the switch logic.
	generate
		for (genvar g = 0; g < `REG_COUNT; g++)
		begin : g_view
			assign reg_bank_out[g] = reg_bank[g];
		end
	endgenerate

	// Device never touches the clock line; data is open drain.
	assign link.sda_d_out = 1'b0;
	assign link.sda_d_oe  = drive_low & mode_s;
endmodule : sw_i2c_device

// ---- rtl/sw_i2c_cfg.svh ----
`ifndef SW_I2C_CFG_SVH
`define SW_I2C_CFG_SVH
// Fixed upper four bits of the seven-bit device address.
`define DEV_ADDR_PREFIX     4'h9
// Reset value of the register pointer and of the register bank.
`define PTR_RESET           8'h00
`define REG_RESET           8'h00
// Number of registers held by the device end.
`define REG_COUNT           8
// Link clock period in ns for standard and fast rates.
`define LINK_PERIOD_STD_NS  10000
`define LINK_PERIOD_FAST_NS 2500
// Core clock period in ns.
`define CORE_PERIOD_NS      5
// Half link period in core cycles, derived from the rates.
`define HALF_STD_CYC        ((`LINK_PERIOD_STD_NS / `CORE_PERIOD_NS) / 2)
`define HALF_FAST_CYC       ((`LINK_PERIOD_FAST_NS / `CORE_PERIOD_NS) / 2)
`endif

// ---- rtl/sw_i2c_pkg.sv ----
package sw_i2c_pkg;
	// Device end states.
	typedef enum logic [2:0] {
		DEV_IDLE  = 3'h0,
		DEV_ADDR  = 3'h1,
		DEV_AACK  = 3'h3,
		DEV_RXB   = 3'h2,
		DEV_RACK  = 3'h6,
		DEV_TXB   = 3'h7,
		DEV_TACK  = 3'h5,
		DEV_SKIP  = 3'h4
	} dev_state_t;
	// Master end states.
	typedef enum logic [2:0] {
		MST_IDLE  = 3'h0,
		MST_START = 3'h1,
		MST_BIT   = 3'h3,
		MST_ACK   = 3'h2,
		MST_STOP  = 3'h6,
		MST_RSTA  = 3'h7
	} mst_state_t;
endpackage : sw_i2c_pkg

// ---- rtl/sw_i2c_if.sv ----
`timescale 1ns/100ps
interface sw_i2c_if;
	// Clock line driven by the master only.
	logic scl_out;
	logic scl_oe;
	// Data line, open drain, driven by either end.
	logic sda_m_out;
	logic sda_m_oe;
	logic sda_d_out;
	logic sda_d_oe;
	logic scl;
	logic sda;
	// Wired level: a line reads low when any enabled driver pulls low.
	assign scl = ~(scl_oe & ~scl_out);
	assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_d_oe & ~sda_d_out));
	modport master (output scl_out, scl_oe, sda_m_out, sda_m_oe, input scl, sda);
	modport device (output sda_d_out, sda_d_oe, input scl, sda);
endinterface : sw_i2c_if

// ---- rtl/sw_i2c_sync.sv ----
`timescale 1ns/100ps
module sw_i2c_sync
(
	// Clock and reset.
	input  wire logic core_clk_in,
	input  wire logic reset_n_in,
	// Asynchronous line levels.
	input  wire logic scl_in,
	input  wire logic sda_in,
	// Synchronised levels and conditions.
	output logic      scl_out,
	output logic      sda_out,
	output logic      scl_rise_out,
	output logic      scl_fall_out,
	output logic      start_out,
	output logic      stop_out
);
	logic [1:0] scl_meta;
	logic [1:0] sda_meta;
	logic       scl_prev;
	logic       sda_prev;

	// Two flip-flops per line; only the second stage is read.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in)
		begin
			scl_meta <= 2'h3;
			sda_meta <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_meta <= {scl_meta[0], scl_in};
			sda_meta <= {sda_meta[0], sda_in};
			scl_prev <= scl_meta[1];
			sda_prev <= sda_meta[1];
		end
	end

	// Edges of the clock line and data edges while clock is high.
	assign scl_out      = scl_meta[1];
	assign sda_out      = sda_meta[1];
	assign scl_rise_out = scl_meta[1] & ~scl_prev;
	assign scl_fall_out = ~scl_meta[1] & scl_prev;
	assign start_out    = scl_meta[1] & scl_prev & sda_prev & ~sda_meta[1];
	assign stop_out     = scl_meta[1] & scl_prev & ~sda_prev & sda_meta[1];
endmodule : sw_i2c_sync

// ---- rtl/sw_i2c_master.sv ----
`timescale 1ns/100ps
`include "sw_i2c_cfg.svh"
module sw_i2c_master
	import sw_i2c_pkg::*;
(
	// Clock and reset.
	input  wire logic       core_clk_in,
	input  wire logic       reset_n_in,
	// Rate select: high picks the fast rate.
	input  wire logic       fast_in,
	// Byte request: start and stop flags frame the byte.
	input  wire logic       req_valid_in,
	input  wire logic       req_start_in,
	input  wire logic       req_stop_in,
	input  wire logic       req_read_in,
	input  wire logic [7:0] req_data_in,
	output logic            req_ready_out,
	// Byte answer.
	output logic            rsp_valid_out,
	output logic [7:0]      rsp_data_out,
	output logic            rsp_ack_out,
	// Two-wire link.
	sw_i2c_if.master        link
);
	mst_state_t state;
	logic [10:0] div;
	logic        phase;
	logic        tick;
	logic [7:0]  shift;
	logic [2:0]  bit_cnt;
	logic        rd;
	logic        stop_after;
	logic        scl_q;
	logic        sda_q;
	logic        sda_drv;
	logic        busy;
	logic [1:0]  sda_meta;

	// Clock divider: two ticks per link period.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in || tick)
		begin
			div <= 11'h000;
		end
		else
		begin
			div <= div + 11'h001;
		end
	end
	assign tick = div == (fast_in ? 11'(`HALF_FAST_CYC - 1) : 11'(`HALF_STD_CYC - 1));

	// Data line sampled through two flip-flops.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in)
		begin
			sda_meta <= 2'h3;
		end
		else
		begin
			sda_meta <= {sda_meta[0], link.sda};
		end
	end

	// Bit engine: phase 0 is clock low, phase 1 is clock high, save MST_START and MST_IDLE, which hold the clock high in phase 0. Every byte
	// without a stop ends with the clock low again, so a repeated start can raise data first.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in)
		begin
			state         <= MST_IDLE;
			scl_q         <= 1'b1;
			sda_q         <= 1'b1;
			phase         <= 1'b0;
			shift         <= 8'h00;
			bit_cnt       <= 3'h0;
			rd            <= 1'b0;
			stop_after    <= 1'b0;
			busy          <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_data_out  <= 8'h00;
			rsp_ack_out   <= 1'b0;
		end
		else
		begin
			rsp_valid_out <= 1'b0;
			if (req_valid_in && req_ready_out)
			begin
				busy       <= 1'b1;
				shift      <= req_data_in;
				rd         <= req_read_in;
				stop_after <= req_stop_in;
				bit_cnt    <= 3'h7;
				phase      <= 1'b0;
				if (!req_start_in)
				begin
					state <= MST_BIT;
				end
				else if (scl_q)
				begin
					state <= MST_START;
				end
				else
				begin
					state <= MST_RSTA;
				end
			end
			else if (tick && busy)
			begin
				phase <= ~phase;
				case (state)
					MST_RSTA:
					begin
						if (!phase)
						begin
							sda_q <= 1'b1;
						end
						else
						begin
							scl_q <= 1'b1;
							state <= MST_START;
						end
					end
					MST_START:
					begin
						if (!phase)
						begin
							sda_q <= 1'b0;
						end
						else
						begin
							scl_q <= 1'b0;
							state <= MST_BIT;
						end
					end
					MST_BIT:
					begin
						if (!phase)
						begin
							scl_q <= 1'b0;
							sda_q <= rd | shift[7];
						end
						else
						begin
							scl_q   <= 1'b1;
							shift   <= {shift[6:0], sda_meta[1]};
							bit_cnt <= bit_cnt - 3'h1;
							if (bit_cnt == 3'h0)
							begin
								state <= MST_ACK;
							end
						end
					end
					MST_ACK:
					begin
						if (!phase)
						begin
							scl_q <= 1'b0;
							sda_q <= !rd;
						end
						else
						begin
							scl_q         <= 1'b1;
							rsp_valid_out <= 1'b1;
							rsp_data_out  <= shift;
							rsp_ack_out   <= !sda_meta[1];
							state         <= MST_STOP;
						end
					end
					MST_STOP:
					begin
						// The clock falls to close the acknowledge slot; without a
						// stop the bus is kept and the next byte may follow.
						if (!phase)
						begin
							scl_q <= 1'b0;
							if (stop_after)
							begin
								sda_q <= 1'b0;
							end
							else
							begin
								busy  <= 1'b0;
								state <= MST_IDLE;
							end
						end
						else
						begin
							scl_q <= 1'b1;
							state <= MST_IDLE;
						end
					end
					MST_IDLE:
					begin
						sda_q <= 1'b1;
						busy  <= 1'b0;
					end
					default:
					begin
						busy  <= 1'b0;
						state <= MST_IDLE;
					end
				endcase
			end
		end
	end

	// Data drive lags the bit engine by one cycle, so the data line never
	// moves in the same cycle as the clock line.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in)
		begin
			sda_drv <= 1'b1;
		end
		else
		begin
			sda_drv <= sda_q;
		end
	end

	// Open-drain drive of both lines; an enable high pulls its line low.
	assign req_ready_out  = !busy;
	assign link.scl_out   = 1'b0;
	assign link.scl_oe    = !scl_q;
	assign link.sda_m_out = 1'b0;
	assign link.sda_m_oe  = !sda_drv;
endmodule : sw_i2c_master

// ---- dv/sw_i2c_asserts.sv ----
`timescale 1ns/100ps
module sw_i2c_asserts
(
	// Clock and reset.
	input  wire logic core_clk_in,
	input  wire logic reset_n_in,
	// Resolved lines and data drive of each end.
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic sda_m_oe,
	input  wire logic sda_d_oe,
	input  wire logic sda_d_out
);
	logic [15:0] low_cnt;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	// Counts cycles since the clock line last fell.
	always_ff @(posedge core_clk_in)
	begin
		if (!reset_n_in || scl)
			low_cnt <= 16'h0;
		else if (low_cnt != 16'hffff)
			low_cnt <= low_cnt + 16'h1;
	end
	// Open-drain drive and ownership of the data line.
	a_dev_drive_low: assert property (sda_d_oe |-> !sda_d_out && !sda)
		else $error("device drives data high");
	a_one_driver: assert property (scl |-> !(sda_d_oe && sda_m_oe))
		else $error("both ends drive data while clock high");
	// The device moves data only just after the clock falls.
	a_dev_edge_time: assert property ($changed(sda_d_oe) |-> !scl && low_cnt inside {[16'h1:16'ha]})
		else $error("device moved data outside the low phase");
	a_data_steady: assert property ($changed(scl) |-> $stable(sda))
		else $error("data moved on a clock edge");
	// Framing conditions keep the clock high around them, and each clock low phase lasts at least 200 cycles.
	a_start_hold: assert property ($fell(sda) && scl |=> scl[*8])
		else $error("clock fell too soon after start");
	a_start_setup: assert property ($fell(sda) && scl |-> $past(scl, 8) && $past(sda, 8))
		else $error("start without data and clock high first");
	a_stop_setup: assert property ($rose(sda) && scl |-> $past(scl, 8))
		else $error("stop without clock high first");
	a_scl_low_time: assert property ($rose(scl) |-> low_cnt >= 16'hc8)
		else $error("clock low phase too short");
endmodule : sw_i2c_asserts

// ---- dv/switch_config_i2c_slave_tb.sv ----
`timescale 1ns/100ps
`include "sw_i2c_cfg.svh"
module switch_config_i2c_slave_tb
	import sw_i2c_pkg::*;
;
	logic       core_clk_in = 1'b0;
	logic       reset_n_in  = 1'b0;
	logic [2:0] addr_sel    = 3'h0;
	logic       mode_serial = 1'b1;
	logic       fast        = 1'b1;
	logic       req_valid   = 1'b0;
	logic       req_start   = 1'b0;
	logic       req_stop    = 1'b0;
	logic       req_read    = 1'b0;
	logic [7:0] req_data    = 8'h0;
	logic       req_ready;
	logic       rsp_valid;
	logic       rsp_ack;
	logic [7:0] rsp_data;
	logic [7:0] reg_ptr;
	logic [7:0] regs [`REG_COUNT];
	logic       wr_pulse;
	logic [7:0] model [`REG_COUNT];
	logic [7:0] wr_count    = 8'h0;
	logic [7:0] ptr_a;
	logic [7:0] p;
	logic [7:0] d;
	int         mismatches  = 0;
	int         checks_done = 0;
	integer     seed        = 32'h496b878b;
	// Clock and store counter.
	always #2.5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in)
		if (wr_pulse === 1'b1)
			wr_count <= wr_count + 8'h1;
	// The two ends joined by the link, with the checker beside it.
	sw_i2c_if sw_i2c_if_inst ();
	sw_i2c_device sw_i2c_device_inst (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
		.addr_sel_in(addr_sel), .mode_serial_in(mode_serial), .link(sw_i2c_if_inst),
		.reg_ptr_out(reg_ptr), .reg_bank_out(regs), .wr_pulse_out(wr_pulse));
	sw_i2c_master sw_i2c_master_inst (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
		.fast_in(fast), .req_valid_in(req_valid), .req_start_in(req_start),
		.req_stop_in(req_stop), .req_read_in(req_read), .req_data_in(req_data),
		.req_ready_out(req_ready), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
		.rsp_ack_out(rsp_ack), .link(sw_i2c_if_inst));
	sw_i2c_asserts sw_i2c_asserts_inst (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
		.scl(sw_i2c_if_inst.scl), .sda(sw_i2c_if_inst.sda), .sda_m_oe(sw_i2c_if_inst.sda_m_oe),
		.sda_d_oe(sw_i2c_if_inst.sda_d_oe), .sda_d_out(sw_i2c_if_inst.sda_d_out));
	// Address byte from the fixed prefix, strap bits and direction.
	function automatic logic [7:0] dev_addr(input logic [2:0] sel, input logic rd);
		return {`DEV_ADDR_PREFIX, sel, rd};
	endfunction : dev_addr
	function automatic logic [7:0] rnd8();
		int r;
		r = $random(seed);
		return r[7:0];
	endfunction : rnd8
	// Comparisons, counted.
	task automatic cmp_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask : cmp_bit
	task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : cmp_byte
	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	// One byte through the master, then its acknowledge and byte are compared.
	task automatic xfer(input logic st, input logic sp, input logic rd, input logic [7:0] dv,
		input logic ack, input logic [7:0] exp_d);
		int n;
		n = 0;
		@(posedge core_clk_in);
		req_valid <= 1'b1;
		req_start <= st;
		req_stop <= sp;
		req_read <= rd;
		req_data <= dv;
		do
		begin
			@(posedge core_clk_in);
			n++;
		end
		while (req_ready !== 1'b1 && n < 40000);
		req_valid <= 1'b0;
		while (rsp_valid !== 1'b1 && n < 40000)
		begin
			@(posedge core_clk_in);
			n++;
		end
		if (n >= 40000)
		begin
			mismatches++;
			close_out();
		end
		else
		begin
			cmp_bit("ack", ack, rsp_ack);
			cmp_byte("byte", exp_d, rsp_data);
		end
	endtask : xfer
	task automatic send(input logic st, input logic sp, input logic [7:0] dv, input logic ack);
		xfer(st, sp, 1'b0, dv, ack, dv);
	endtask : send
	// Main sequence.
	initial
	begin
		for (int i = 0; i < `REG_COUNT; i++)
			model[i] = `REG_RESET;
		repeat (20) @(posedge core_clk_in);
		ptr_a = rnd8();
		addr_sel <= ptr_a[2:0];
		reset_n_in <= 1'b1;
		@(posedge core_clk_in);
		cmp_byte("pointer", `PTR_RESET, reg_ptr);
		$display("test reset finished");
		ptr_a = rnd8() & 8'h07;
		for (int i = 0; i < 2; i++)
		begin
			p = i ? (rnd8() & 8'h07) : ptr_a;
			d = i ? rnd8() : 8'hff;
			model[p[2:0]] = d;
			send(1'b1, 1'b0, dev_addr(addr_sel, 1'b0), 1'b1);
			send(1'b0, 1'b0, p, 1'b1);
			send(1'b0, i == 1, d, 1'b1);
		end
		cmp_byte("pointer", p, reg_ptr);
		$display("test write finished");
		send(1'b1, 1'b0, dev_addr(addr_sel, 1'b0), 1'b1);
		send(1'b0, 1'b0, ptr_a, 1'b1);
		send(1'b1, 1'b0, dev_addr(addr_sel, 1'b1), 1'b1);
		xfer(1'b0, 1'b1, 1'b1, 8'hff, 1'b1, model[ptr_a[2:0]]);
		send(1'b1, 1'b0, dev_addr(addr_sel ^ 3'h5, 1'b0), 1'b0);
		send(1'b1, 1'b0, dev_addr(addr_sel, 1'b1), 1'b1);
		xfer(1'b0, 1'b1, 1'b1, 8'hff, 1'b1, model[ptr_a[2:0]]);
		$display("test read finished");
		mode_serial <= 1'b0;
		send(1'b1, 1'b1, dev_addr(addr_sel, 1'b0), 1'b0);
		mode_serial <= 1'b1;
		fast <= 1'b0;
		send(1'b1, 1'b1, dev_addr(addr_sel, 1'b0), 1'b1);
		cmp_byte("stores", 8'h02, wr_count);
		for (int i = 0; i < `REG_COUNT; i++)
			cmp_byte("register", model[i], regs[i]);
		$display("test mode and rate finished");
		close_out();
	end
endmodule : switch_config_i2c_slave_tb
